// ### hw/lcr_pkg.sv
/*
  Constants of the lane conditioning register bank: offsets, field
  positions, reset values, strap and code values.
  Assumes nothing of its surroundings; imported by the register bank, the host model and the testbench.
*/
package lcr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_OVERRIDE = 8'h08;
  localparam logic [7:0] OFS_CH0_DEEMPH = 8'h11;
  localparam logic [7:0] OFS_CH0_IDLE_THR = 8'h12;
  localparam logic [7:0] OFS_CH1_IDLE_RATE = 8'h15;
  localparam logic [7:0] OFS_CH1_EQ = 8'h16;
  localparam logic [7:0] OFS_CH1_SWING = 8'h17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_DEEMPH = 8'h03;
  localparam logic [7:0] RST_IDLE_THR = 8'h00;
  localparam logic [7:0] RST_IDLE_RATE = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h20;
  localparam logic [7:0] RST_SWING = 8'h03;

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int POS_DEEMPH_TYPE = 7;
  localparam int POS_OVR_IDLE = 4;
  localparam int POS_OVR_RATE = 2;
  localparam int POS_IDLE_AUTO = 5;
  localparam int POS_IDLE_SEL = 4;
  localparam int POS_RATE_AUTO = 1;
  localparam int POS_RATE_SEL = 0;
  localparam int POS_EQ_EN = 5;
  localparam logic [7:0] MASK_OVERRIDE = 8'h14;
  localparam logic [7:0] MASK_IDLE_THR = 8'h0f;
  localparam logic [7:0] MASK_IDLE_RATE = 8'h33;
  localparam logic [7:0] MASK_SIX_BIT = 8'h3f;

  // ----------------------------------------------------------------
  // Strap pin levels, two bits per pin
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_FLOAT = 2'h2;

  // ----------------------------------------------------------------
  // De-emphasis codes
  // ----------------------------------------------------------------
  localparam logic [7:0] DEEMPH_0DB0 = 8'h01;
  localparam logic [7:0] DEEMPH_3DB5 = 8'h38;
  localparam logic [7:0] DEEMPH_6DB0 = 8'h88;
  localparam logic [7:0] DEEMPH_9DB0 = 8'h90;
  localparam logic [7:0] DEEMPH_12DB0 = 8'ha0;
  localparam logic [7:0] DEEMPH_RESERVED = 8'hc0;

  // ----------------------------------------------------------------
  // Equalizer codes
  // ----------------------------------------------------------------
  localparam logic [5:0] EQ_BYPASS = 6'h20;
  localparam logic [5:0] EQ_2A = 6'h2a;
  localparam logic [5:0] EQ_30 = 6'h30;
  localparam logic [5:0] EQ_31 = 6'h31;
  localparam logic [5:0] EQ_38 = 6'h38;
  localparam logic [5:0] EQ_34 = 6'h34;
  localparam logic [5:0] EQ_35 = 6'h35;
  localparam logic [5:0] EQ_3A = 6'h3a;
  localparam logic [5:0] EQ_3C = 6'h3c;

  // ----------------------------------------------------------------
  // Output swing codes
  // ----------------------------------------------------------------
  localparam logic [5:0] SWING_600MV = 6'h03;
  localparam logic [5:0] SWING_800MV = 6'h07;
  localparam logic [5:0] SWING_1000MV = 6'h0f;
  localparam logic [5:0] SWING_1200MV = 6'h1f;
  localparam logic [5:0] SWING_1400MV = 6'h3f;

  // Width of the bundle of pin inputs that is synchronised
  localparam int PIN_BUS_W = 11;

endpackage

// ### hw/lcr_pin_sync.sv
/*
  Three-stage synchroniser for a bundle of pin inputs.
  Assumes the pins are asynchronous and slow; a new value is taken once
  the second and third stages agree.
*/
`timescale 1ns/100ps

module lcr_pin_sync #(
  parameter int WIDTH = 11
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Raw pins and their stable image
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1_reg; // Read only by stage two
  logic [WIDTH-1:0] stage2_reg; // Second stage
  logic [WIDTH-1:0] stage3_reg; // Third stage
  logic [WIDTH-1:0] stable_reg; // Agreed value
  logic [WIDTH-1:0] stable_next;

  // Take a bit only where stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      stable_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : stable_reg[i];
    end
  end

  // Register the chain
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      stable_reg <= '0;
    end else begin
      stage1_reg <= pins_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      stable_reg <= stable_next;
    end
  end

  assign pins_out = stable_reg;

endmodule // lcr_pin_sync

// ### hw/lcr_cfg_regs.sv
/*
  Channel configuration register bank of a lane conditioning repeater:
  register port from the management bus engine, strap decode, and the
  registered settings driven to the analog lanes.
  Assumes a management bus engine on the same clock presenting single
  byte reads and writes, and strap / control pins from outside.
*/
`timescale 1ns/100ps

// Operation
// R1 - De-emphasis byte: type bit, level, reset 03
// R2 - Codes 01,38,88,90,A0 select de-emphasis strengths
// R3 - Host never writes reserved de-emphasis code C0
// R4 - Strap pair maps to one de-emphasis code
// R5 - Idle threshold: 3:2 de-assert, 1:0 assert
// R6 - Threshold code picks de-assert/assert voltage pair
// R7 - Idle-auto bit selects automatic idle detection
// R8 - Forced idle bit mutes or enables output
// R9 - Rate-auto bit selects automatic rate detection
// R10 - Forced rate bit picks low or high range
// R11 - Equalizer: enable, gain stage, boost level
// R12 - Equalizer resets to 20h bypass
// R13 - Equalizer strap pair maps to register code
// R14 - Six-bit output swing, top bits read zero
// R15 - Override bit 4 blocks idle pin
// R16 - Override bit 2 blocks rate pin
// R17 - Reads return last written value or default
module lcr_cfg_regs
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  // Strap and control pins, each strap pin coded low/high/float
  input wire logic [1:0] deemph_strap_hi_in,
  input wire logic [1:0] deemph_strap_lo_in,
  input wire logic [1:0] eq_strap_a_in,
  input wire logic [1:0] eq_strap_b_in,
  input wire logic strap_mode_in,
  input wire logic idle_pin_in,
  input wire logic rate_pin_in,
  // Settings to the lanes
  output logic [7:0] deemph_setting_out,
  output logic [1:0] idle_deassert_thr_out,
  output logic [1:0] idle_assert_thr_out,
  output logic idle_auto_out,
  output logic idle_mute_out,
  output logic rate_auto_out,
  output logic rate_high_out,
  output logic rx_equalizer_en_out,
  output logic [1:0] gain_stage_out,
  output logic [2:0] boost_level_out,
  output logic [5:0] output_swing_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Map a de-emphasis strap pair to its register code
  function automatic logic [7:0] deemph_decode(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] pair;
    pair = {hi, lo};
    case (pair)
      {PIN_LOW, PIN_LOW}: deemph_decode = DEEMPH_0DB0;
      {PIN_LOW, PIN_HIGH}: deemph_decode = DEEMPH_3DB5;
      {PIN_LOW, PIN_FLOAT}: deemph_decode = DEEMPH_6DB0;
      {PIN_HIGH, PIN_FLOAT}: deemph_decode = DEEMPH_12DB0;
      {PIN_FLOAT, PIN_LOW}: deemph_decode = DEEMPH_9DB0;
      {PIN_FLOAT, PIN_HIGH}: deemph_decode = DEEMPH_12DB0;
      {PIN_FLOAT, PIN_FLOAT}: deemph_decode = DEEMPH_RESERVED;
      default: deemph_decode = RST_DEEMPH;
    endcase
  endfunction

  // Map an equalizer strap pair to its register code
  function automatic logic [5:0] eq_decode(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] pair;
    pair = {a, b};
    case (pair)
      {PIN_HIGH, PIN_HIGH}: eq_decode = EQ_2A;
      {PIN_LOW, PIN_LOW}: eq_decode = EQ_30;
      {PIN_LOW, PIN_FLOAT}: eq_decode = EQ_31;
      {PIN_LOW, PIN_HIGH}: eq_decode = EQ_38;
      {PIN_HIGH, PIN_FLOAT}: eq_decode = EQ_34;
      {PIN_HIGH, PIN_LOW}: eq_decode = EQ_35;
      {PIN_FLOAT, PIN_LOW}: eq_decode = EQ_3A;
      {PIN_FLOAT, PIN_HIGH}: eq_decode = EQ_3C;
      default: eq_decode = EQ_BYPASS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [PIN_BUS_W-1:0] pins_raw; // Bundle of raw pins
  logic [PIN_BUS_W-1:0] pins_sync; // Stable image
  logic [1:0] dh_s, dl_s, ea_s, eb_s; // Synchronised straps
  logic mode_s, idle_s, rate_s; // Synchronised control pins

  assign pins_raw = {deemph_strap_hi_in, deemph_strap_lo_in, eq_strap_a_in,
                     eq_strap_b_in, strap_mode_in, idle_pin_in, rate_pin_in};
  assign {dh_s, dl_s, ea_s, eb_s, mode_s, idle_s, rate_s} = pins_sync;

  lcr_pin_sync #(.WIDTH(PIN_BUS_W)) u_pin_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pins_in(pins_raw),
    .pins_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] override_reg, override_next; // Pin control override
  logic [7:0] deemph_reg, deemph_next; // Channel 0 de-emphasis
  logic [7:0] thr_reg, thr_next; // Channel 0 idle thresholds
  logic [7:0] idlerate_reg, idlerate_next; // Channel 1 idle / rate
  logic [7:0] eq_reg, eq_next; // Channel 1 equalizer
  logic [7:0] swing_reg, swing_next; // Channel 1 output swing
  logic [7:0] rdata_next; // Read mux
  logic wr_ovr, wr_dem, wr_thr, wr_ir, wr_eq, wr_sw; // Write decodes

  assign wr_ovr = reg_wr_in && (reg_addr_in == OFS_PIN_OVERRIDE);
  assign wr_dem = reg_wr_in && (reg_addr_in == OFS_CH0_DEEMPH);
  assign wr_thr = reg_wr_in && (reg_addr_in == OFS_CH0_IDLE_THR);
  assign wr_ir = reg_wr_in && (reg_addr_in == OFS_CH1_IDLE_RATE);
  assign wr_eq = reg_wr_in && (reg_addr_in == OFS_CH1_EQ);
  assign wr_sw = reg_wr_in && (reg_addr_in == OFS_CH1_SWING);

  // Next register values; reserved bits are stored as zero
  always_comb begin
    // R1 full byte store
    deemph_next = wr_dem ? reg_wdata_in : deemph_reg;
    // R5 reserved nibble dropped
    thr_next = wr_thr ? (reg_wdata_in & MASK_IDLE_THR) : thr_reg;
    override_next = wr_ovr ? (reg_wdata_in & MASK_OVERRIDE) : override_reg;
    idlerate_next = wr_ir ? (reg_wdata_in & MASK_IDLE_RATE) : idlerate_reg;
    eq_next = wr_eq ? (reg_wdata_in & MASK_SIX_BIT) : eq_reg;
    // R14 swing top bits zero
    swing_next = wr_sw ? (reg_wdata_in & MASK_SIX_BIT) : swing_reg;
  end

  // Read mux; unmapped offsets return zero
  always_comb begin
    // R17 read back stored value
    case (reg_addr_in)
      OFS_PIN_OVERRIDE: rdata_next = override_reg;
      OFS_CH0_DEEMPH: rdata_next = deemph_reg;
      OFS_CH0_IDLE_THR: rdata_next = thr_reg;
      OFS_CH1_IDLE_RATE: rdata_next = idlerate_reg;
      OFS_CH1_EQ: rdata_next = eq_reg;
      OFS_CH1_SWING: rdata_next = swing_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Register file and read answer
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      // R12 equalizer bypass default
      eq_reg <= RST_EQ;
      override_reg <= RST_PIN_OVERRIDE;
      deemph_reg <= RST_DEEMPH;
      thr_reg <= RST_IDLE_THR;
      idlerate_reg <= RST_IDLE_RATE;
      swing_reg <= RST_SWING;
      reg_rdata_out <= 8'h00;
      reg_ack_out <= 1'b0;
    end else begin
      eq_reg <= eq_next;
      override_reg <= override_next;
      deemph_reg <= deemph_next;
      thr_reg <= thr_next;
      idlerate_reg <= idlerate_next;
      swing_reg <= swing_next;
      reg_rdata_out <= reg_rd_in ? rdata_next : 8'h00;
      reg_ack_out <= reg_rd_in || reg_wr_in;
    end
  end

  // ----------------------------------------------------------------
  // Effective lane settings
  // ----------------------------------------------------------------
  logic [7:0] dem_eff; // De-emphasis to lane
  logic [5:0] eq_eff; // Equalizer to lane
  logic idle_auto_eff, idle_mute_eff, rate_auto_eff, rate_high_eff;

  // Choose register or strap / pin sources
  always_comb begin
    // R4 strap sets de-emphasis
    dem_eff = mode_s ? deemph_decode(dh_s, dl_s) : deemph_reg;
    // R13 strap sets equalizer
    eq_eff = mode_s ? eq_decode(ea_s, eb_s) : eq_reg[5:0];
    // R15 idle pin gating
    if (override_reg[POS_OVR_IDLE]) begin
      // R7 R8 register idle control
      idle_auto_eff = idlerate_reg[POS_IDLE_AUTO];
      idle_mute_eff = !idlerate_reg[POS_IDLE_AUTO] && idlerate_reg[POS_IDLE_SEL];
    end else begin
      idle_auto_eff = 1'b0;
      idle_mute_eff = idle_s;
    end
    // R16 rate pin gating
    if (override_reg[POS_OVR_RATE]) begin
      // R9 R10 register rate control
      rate_auto_eff = idlerate_reg[POS_RATE_AUTO];
      rate_high_eff = !idlerate_reg[POS_RATE_AUTO] && idlerate_reg[POS_RATE_SEL];
    end else begin
      rate_auto_eff = 1'b0;
      rate_high_eff = rate_s;
    end
  end

  // Register the settings driven to the lanes
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      deemph_setting_out <= RST_DEEMPH;
      idle_deassert_thr_out <= 2'h0;
      idle_assert_thr_out <= 2'h0;
      idle_auto_out <= 1'b0;
      idle_mute_out <= 1'b0;
      rate_auto_out <= 1'b0;
      rate_high_out <= 1'b0;
      rx_equalizer_en_out <= 1'b1;
      gain_stage_out <= 2'h0;
      boost_level_out <= 3'h0;
      output_swing_out <= SWING_600MV;
    end else begin
      // R2 code passed to driver
      deemph_setting_out <= dem_eff;
      // R6 threshold pair codes
      idle_deassert_thr_out <= thr_reg[3:2];
      idle_assert_thr_out <= thr_reg[1:0];
      idle_auto_out <= idle_auto_eff;
      idle_mute_out <= idle_mute_eff;
      rate_auto_out <= rate_auto_eff;
      rate_high_out <= rate_high_eff;
      // R11 equalizer fields split
      rx_equalizer_en_out <= eq_eff[POS_EQ_EN];
      gain_stage_out <= eq_eff[4:3];
      boost_level_out <= eq_eff[2:0];
      output_swing_out <= swing_reg[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr(logic [7:0] ofs);
    reg_wr_in && reg_addr_in == ofs;
  endsequence

  a_deemph_store: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
    s_wr(OFS_CH0_DEEMPH) |=> deemph_reg == $past(reg_wdata_in))
    else $error("de-emphasis write not stored");
  a_deemph_drive: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
    !mode_s ##1 !mode_s |-> deemph_setting_out == $past(deemph_reg))
    else $error("de-emphasis code not driven");
  a_deemph_strap: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
    mode_s |=> deemph_setting_out == $past(deemph_decode(dh_s, dl_s)))
    else $error("de-emphasis strap decode wrong");
  a_thr_mask: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
    s_wr(OFS_CH0_IDLE_THR) |=> thr_reg == {4'h0, $past(reg_wdata_in[3:0])})
    else $error("threshold write not masked");
  a_thr_fields: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
    s_wr(OFS_CH0_IDLE_THR) |=> ##1 {idle_deassert_thr_out, idle_assert_thr_out}
      == $past(reg_wdata_in[3:0], 2))
    else $error("threshold codes not driven");
  a_idle_auto: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
    override_reg[POS_OVR_IDLE] |=> idle_auto_out == $past(idlerate_reg[POS_IDLE_AUTO]))
    else $error("idle auto not followed");
  a_idle_forced: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R8
    override_reg[POS_OVR_IDLE] && !idlerate_reg[POS_IDLE_AUTO]
      |=> idle_mute_out == $past(idlerate_reg[POS_IDLE_SEL]))
    else $error("forced idle not followed");
  a_rate_sel: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R9
    override_reg[POS_OVR_RATE] |=> rate_auto_out == $past(idlerate_reg[POS_RATE_AUTO])
      && rate_high_out == $past(!idlerate_reg[POS_RATE_AUTO] && idlerate_reg[POS_RATE_SEL]))
    else $error("rate selection not followed");
  a_eq_split: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
    !mode_s |=> {rx_equalizer_en_out, gain_stage_out, boost_level_out} == $past(eq_reg[5:0]))
    else $error("equalizer fields wrong");
  a_reset_vals: assert property (@(posedge clock_in) // R12
    $rose(rst_n_in) |-> eq_reg == RST_EQ && deemph_reg == RST_DEEMPH && swing_reg == RST_SWING)
    else $error("reset defaults wrong");
  a_eq_strap: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R13
    mode_s |=> {rx_equalizer_en_out, gain_stage_out, boost_level_out}
      == $past(eq_decode(ea_s, eb_s)))
    else $error("equalizer strap decode wrong");
  a_swing_mask: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
    s_wr(OFS_CH1_SWING) |=> swing_reg[7:6] == 2'h0 ##1 output_swing_out == $past(swing_reg[5:0]))
    else $error("swing field wrong");
  a_idle_pin: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R15
    !override_reg[POS_OVR_IDLE] |=> idle_mute_out == $past(idle_s) && !idle_auto_out)
    else $error("idle pin not followed");
  a_rate_pin: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R16
    !override_reg[POS_OVR_RATE] |=> rate_high_out == $past(rate_s) && !rate_auto_out)
    else $error("rate pin not followed");
  a_read_back: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R17
    reg_rd_in && reg_addr_in == OFS_CH1_EQ |=> reg_rdata_out == $past(eq_reg) && reg_ack_out)
    else $error("read back wrong");

endmodule // lcr_cfg_regs

// ### testbench/lcr_host_model.sv
/*
  Behavioural model of the management bus host writing channel settings.
  Assumes the bank answers each strobe with ack one cycle later.
*/
`timescale 1ns/100ps

module lcr_host_model
  import lcr_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Register port toward the bank
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_ack_in
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // One byte access: one-cycle strobe, answer taken with the ack
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rdata, output logic ack);
    logic [7:0] wd;
    wd = data;
    if (wr && addr == OFS_CH0_DEEMPH && wd == DEEMPH_RESERVED) begin
      wd = RST_DEEMPH;
    end
    @(posedge clock_in);
    #10;
    reg_addr_out = addr;
    reg_wdata_out = wd;
    reg_wr_out = wr;
    reg_rd_out = ~wr;
    @(posedge clock_in);
    #10;
    ack = reg_ack_in;
    rdata = reg_rdata_in;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // Released lines never keep the old value
    reg_addr_out = ~addr;
    reg_wdata_out = ~wd;
  endtask
endmodule // lcr_host_model

// ### testbench/testbench.sv
/*
  Self-checking bench of the lane conditioning register bank.
  Assumes the host model drives the register port; pins come from here.
*/
`timescale 1ns/100ps

module testbench
  import lcr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_in, rst_n_in;
  logic [7:0] addr, wdata, rdata, deemph;
  logic wr, rd, ack, smode, idle_pin, rate_pin;
  logic i_auto, i_mute, r_auto, r_high, eq_en;
  logic [1:0] dhi, dlo, eqa, eqb, thr_d, thr_a, gain;
  logic [2:0] boost;
  logic [5:0] swing;
  int errors, checked;

  lcr_cfg_regs u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_ack_out(ack), .deemph_strap_hi_in(dhi), .deemph_strap_lo_in(dlo),
    .eq_strap_a_in(eqa), .eq_strap_b_in(eqb), .strap_mode_in(smode),
    .idle_pin_in(idle_pin), .rate_pin_in(rate_pin), .deemph_setting_out(deemph),
    .idle_deassert_thr_out(thr_d), .idle_assert_thr_out(thr_a), .idle_auto_out(i_auto),
    .idle_mute_out(i_mute), .rate_auto_out(r_auto), .rate_high_out(r_high),
    .rx_equalizer_en_out(eq_en), .gain_stage_out(gain), .boost_level_out(boost),
    .output_swing_out(swing));

  lcr_host_model u_host (.clock_in(clock_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_ack_in(ack));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    u_host.access(1'b1, a, d, r, k);
    check({7'h00, k}, 8'h01, "write ack");
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] r;
    logic k;
    u_host.access(1'b0, a, 8'h00, r, k);
    check({7'h00, k}, 8'h01, "read ack");
    check(r, exp, what);
  endtask

  // Lets register and pin changes reach the lane outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
    #10;
  endtask

  task automatic finish_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rreg(OFS_PIN_OVERRIDE, 8'h00, "override reset");
    rreg(OFS_CH0_DEEMPH, 8'h03, "deemph reset");
    rreg(OFS_CH0_IDLE_THR, 8'h00, "threshold reset");
    rreg(OFS_CH1_IDLE_RATE, 8'h00, "idle rate reset");
    rreg(OFS_CH1_EQ, 8'h20, "eq reset");
    rreg(OFS_CH1_SWING, 8'h03, "swing reset");
    check({eq_en, gain, boost, 2'h0}, 8'h80, "eq out reset");
    check({2'h0, swing}, 8'h03, "swing out reset");
  endtask

  task automatic t_masks();
    logic [7:0] a[6] = '{8'h08, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17};
    logic [7:0] m[6] = '{8'h14, 8'hff, 8'h0f, 8'h33, 8'h3f, 8'h3f};
    for (int i = 0; i < 6; i++) begin
      wreg(a[i], 8'hff);
      rreg(a[i], m[i], "reserved bits");
    end
    wreg(8'h13, 8'h5a);
    rreg(8'h13, 8'h00, "unmapped read");
  endtask

  task automatic t_deemph();
    logic [7:0] c[5] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'ha0};
    for (int i = 0; i < 5; i++) begin
      wreg(OFS_CH0_DEEMPH, c[i]);
      settle(2);
      check(deemph, c[i], "deemph out");
    end
  endtask

  task automatic t_thr();
    for (int i = 0; i < 16; i++) begin
      wreg(OFS_CH0_IDLE_THR, 8'(i));
      settle(2);
      check({4'h0, thr_d, thr_a}, 8'(i), "threshold out");
    end
  endtask

  task automatic t_idle_rate();
    logic [3:0] v, e;
    wreg(OFS_PIN_OVERRIDE, 8'h14);
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      e = {v[3], v[2] & ~v[3], v[1], v[0] & ~v[1]};
      wreg(OFS_CH1_IDLE_RATE, {2'h0, v[3:2], 2'h0, v[1:0]});
      settle(2);
      check({4'h0, i_auto, i_mute, r_auto, r_high}, {4'h0, e}, "idle rate");
    end
  endtask

  task automatic t_eq_swing();
    logic [5:0] q[4] = '{6'h20, 6'h2a, 6'h3c, 6'h31};
    logic [5:0] s[5] = '{6'h03, 6'h07, 6'h0f, 6'h1f, 6'h3f};
    for (int i = 0; i < 4; i++) begin
      wreg(OFS_CH1_EQ, {2'h0, q[i]});
      settle(2);
      check({2'h0, eq_en, gain, boost}, {2'h0, q[i]}, "eq fields");
    end
    for (int i = 0; i < 5; i++) begin
      wreg(OFS_CH1_SWING, {2'h0, s[i]});
      settle(2);
      check({2'h0, swing}, {2'h0, s[i]}, "swing out");
    end
  endtask

  task automatic t_pins();
    wreg(OFS_PIN_OVERRIDE, 8'h00);
    idle_pin = 1'b1;
    rate_pin = 1'b1;
    settle(8);
    check({4'h0, i_auto, i_mute, r_auto, r_high}, 8'h05, "pins allowed");
    wreg(OFS_PIN_OVERRIDE, 8'h14);
    wreg(OFS_CH1_IDLE_RATE, 8'h00);
    settle(2);
    check({4'h0, i_auto, i_mute, r_auto, r_high}, 8'h00, "pins blocked");
    idle_pin = 1'b0;
    rate_pin = 1'b0;
  endtask

  task automatic t_straps();
    // Entries: {first pin, second pin, code}; pin 0 low, 1 high, 2 float
    // Unlisted pairs fall back to the reset code; de-emphasis float/float gives the reserved code
    logic [11:0] d[9] = '{12'h001, 12'h138, 12'h288, 12'h6a0, 12'h890, 12'h9a0,
                          12'h403, 12'h503, 12'hac0};
    logic [11:0] q[9] = '{12'h52a, 12'h030, 12'h231, 12'h138, 12'h634, 12'h435,
                          12'h83a, 12'h93c, 12'ha20};
    smode = 1'b1;
    for (int i = 0; i < 9; i++) begin
      {eqa, eqb} = q[i][11:8];
      {dhi, dlo} = d[i][11:8];
      settle(8);
      check({2'h0, eq_en, gain, boost}, q[i][7:0], "eq strap");
      check(deemph, d[i][7:0], "deemph strap");
    end
    smode = 1'b0;
    settle(8);
    check(deemph, 8'ha0, "register after straps");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  initial begin
    errors = 0;
    checked = 0;
    rst_n_in = 1'b0;
    {dhi, dlo, eqa, eqb} = 8'h00;
    {smode, idle_pin, rate_pin} = 3'h0;
    repeat (2) @(posedge clock_in);
    #10 rst_n_in = 1'b1;
    t_reset();
    t_masks();
    t_deemph();
    t_thr();
    t_idle_rate();
    t_eq_swing();
    t_pins();
    t_straps();
    finish_test();
  end

  initial begin
    #(5000 * 100);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
endmodule // testbench
